// ==== pkg/clock_gen_regs.svh ====
`ifndef CLOCK_GEN_REGS_SVH
`define CLOCK_GEN_REGS_SVH

// =====================================================================
// Watchdog preset, counter layout and prescaler taps.
`define WDT_PRESET 12'hFFF
`define WDT_WIDTH 12
`define WDT_MSB 11
`define PRE_WIDTH 10
`define F32_BITS 5
`define WDT_TAP_FAST 4
`define WDT_TAP_SLOW 9

// =====================================================================
// Reset values.
`define OSC_EN_RST 1'b1
`define PHI_RST 1'b0
`define BUS_RST 1'b0

`endif

// ==== pkg/clock_gen_pkg.sv ====
package clock_gen_pkg;

    // =================================================================
    // Power states, Gray coded along run, stop, settle, wait.
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_STOP = 2'b01,
        ST_SETTLE = 2'b11,
        ST_WAIT = 2'b10
    } pwr_state_e;

    // =================================================================
    // Requests from the instruction decoder and interrupt logic.
    typedef struct packed {
        logic halt_oscillator_instruction;
        logic idle_cpu_clock_instruction;
        logic irq_accept;
    } cpu_req_s;

    // =================================================================
    // Software controls of the watchdog.
    typedef struct packed {
        logic restart;
        logic freq_sel;
    } wdt_ctrl_s;

endpackage : clock_gen_pkg

// ==== rtl/stop_watchdog.sv ====
`timescale 1ns/100ps
`include "clock_gen_regs.svh"

module stop_watchdog #(
    parameter int WIDTH = `WDT_WIDTH
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic xin_tick_i,
    input wire logic stop_load_i,
    input wire clock_gen_pkg::wdt_ctrl_s ctrl_i,
    output logic [WIDTH-1:0] count_o,
    output logic f32_sel_o
);
    import clock_gen_pkg::*;

    logic [`PRE_WIDTH-1:0] pre_reg;
    logic [WIDTH-1:0] count_reg;
    logic sel_reg;
    logic f32_tick;
    logic norm_tick;
    logic dec_tick;

    generate
        if (WIDTH != `WDT_WIDTH) begin : g_bad_width
            $error("stop_watchdog: WIDTH must match the preset width");
        end
    endgenerate

    // True when the low bits of the prescaler are all ones.
    function automatic logic tap_hit(input logic [`PRE_WIDTH-1:0] pre,
                                     input int bits);
        logic [`PRE_WIDTH-1:0] mask;
        mask = `PRE_WIDTH'((1 << bits) - 1);
        return (pre & mask) == mask;
    endfunction : tap_hit

    // =================================================================
    // Prescaler on the oscillator input.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pre_reg <= '0;
        end else if (xin_tick_i) begin
            pre_reg <= pre_reg + `PRE_WIDTH'(1);
        end
    end

    assign f32_tick = xin_tick_i && tap_hit(pre_reg, `F32_BITS);
    assign norm_tick = xin_tick_i && tap_hit(pre_reg,
        ctrl_i.freq_sel ? `WDT_TAP_FAST : `WDT_TAP_SLOW);
    assign dec_tick = sel_reg ? f32_tick : norm_tick;

    // =================================================================
    // Count source selection.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sel_reg <= 1'b0;
        end else if (stop_load_i) begin
            sel_reg <= 1'b1;
        end else if (sel_reg && !count_reg[`WDT_MSB]) begin
            sel_reg <= 1'b0;
        end
    end

    // =================================================================
    // Down counter.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            count_reg <= `WDT_PRESET;
        end else if (stop_load_i || ctrl_i.restart) begin
            count_reg <= `WDT_PRESET;
        end else if (dec_tick) begin
            count_reg <= count_reg - WIDTH'(1);
        end
    end

    assign count_o = count_reg;
    assign f32_sel_o = sel_reg;

    // =================================================================
    // Checks.
    chk_f32_decrement: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        (sel_reg && f32_tick && !stop_load_i && !ctrl_i.restart)
            |=> count_reg == $past(count_reg) - WIDTH'(1))
        else $error("watchdog did not step on the divided-by-32 tick");

    chk_f32_only: assert property (
        @(posedge mclk_i) disable iff (srst_i)
        (sel_reg && !f32_tick && !stop_load_i && !ctrl_i.restart)
            |=> $stable(count_reg))
        else $error("watchdog stepped off the divided-by-32 tick");

endmodule : stop_watchdog

// ==== rtl/clock_gen_stop_wait.sv ====
`timescale 1ns/100ps
`include "clock_gen_regs.svh"

// Behaviour
// - Internal CPU clock is oscillator input halved.
// - Bus cycle is internal clock halved again.
// - Oscillation-control flip-flop gates the amplifier.
// - Stop instruction halts oscillator, clock held low.
// - Stop presets watchdog FFF, counts divided-by-32.
// - Watchdog source restored when MSB clears, reset.
// - Interrupt restarts oscillator; clock waits for MSB.
// - Wait instruction holds clock low, oscillator runs.
// - Peripheral clock keeps running during wait.
// - Interrupt ends wait at once, no settling.
module clock_gen_stop_wait (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic osc_in_i,
    input wire clock_gen_pkg::cpu_req_s req_i,
    input wire clock_gen_pkg::wdt_ctrl_s wdt_ctrl_i,
    output logic osc_output_pin_o,
    output logic osc_enable_o,
    output logic phi_o,
    output logic phi_tick_o,
    output logic bus_clk_o,
    output logic periph_tick_o,
    output clock_gen_pkg::pwr_state_e power_state_o,
    output logic [`WDT_WIDTH-1:0] wdt_count_o,
    output logic wdt_f32_sel_o
);
    import clock_gen_pkg::*;

    pwr_state_e state_reg;
    logic osc_prev_reg;
    logic osc_en_reg;
    logic osc_out_reg;
    logic phi_reg;
    logic phi_tick_reg;
    logic bus_reg;
    logic periph_phase_reg;
    logic periph_tick_reg;
    logic xin_tick;
    logic run;
    logic stop_go;
    logic wait_go;
    logic [`WDT_WIDTH-1:0] wdt_count;
    logic wdt_sel;

    // =================================================================
    // Oscillator edge detection; no edges while the gate is closed.
    // The pin is tracked through reset so that no false edge follows it.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            osc_prev_reg <= osc_in_i;
        end else begin
            osc_prev_reg <= osc_in_i;
        end
    end

    assign xin_tick = osc_in_i && !osc_prev_reg && osc_en_reg;
    assign run = state_reg == ST_RUN;
    assign stop_go = run && req_i.halt_oscillator_instruction;
    assign wait_go = run && !req_i.halt_oscillator_instruction
        && req_i.idle_cpu_clock_instruction;

    // =================================================================
    // Power state.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_reg <= ST_RUN;
        end else begin
            case (state_reg)
                ST_RUN: begin
                    if (stop_go) begin
                        state_reg <= ST_STOP;
                    end else if (wait_go) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_STOP: begin
                    if (req_i.irq_accept) begin
                        state_reg <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (!wdt_count[`WDT_MSB]) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_WAIT: begin
                    if (req_i.irq_accept) begin
                        state_reg <= ST_RUN;
                    end
                end
                default: begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end

    // =================================================================
    // Oscillation-control flip-flop and amplifier output.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            osc_en_reg <= `OSC_EN_RST;
        end else if (stop_go) begin
            osc_en_reg <= 1'b0;
        end else if (state_reg == ST_STOP && req_i.irq_accept) begin
            osc_en_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            osc_out_reg <= 1'b0;
        end else begin
            osc_out_reg <= osc_en_reg && !osc_in_i;
        end
    end

    // =================================================================
    // Internal clock, halved from the oscillator.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            phi_reg <= `PHI_RST;
        end else if (stop_go || wait_go) begin
            phi_reg <= 1'b0;
        end else if (run && xin_tick) begin
            phi_reg <= !phi_reg;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            phi_tick_reg <= 1'b0;
        end else begin
            phi_tick_reg <= run && xin_tick && !phi_reg
                && !stop_go && !wait_go;
        end
    end

    // =================================================================
    // Bus cycle, halved from the internal clock.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            bus_reg <= `BUS_RST;
        end else if (stop_go || wait_go) begin
            bus_reg <= 1'b0;
        end else if (run && xin_tick && !phi_reg) begin
            bus_reg <= !bus_reg;
        end
    end

    // =================================================================
    // Peripheral clock at the internal clock rate, alive in wait.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            periph_phase_reg <= 1'b0;
        end else if (xin_tick) begin
            periph_phase_reg <= !periph_phase_reg;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            periph_tick_reg <= 1'b0;
        end else begin
            periph_tick_reg <= xin_tick && periph_phase_reg
                && (run || state_reg == ST_WAIT);
        end
    end

    // =================================================================
    // Watchdog used for stop recovery.
    stop_watchdog #(
        .WIDTH(`WDT_WIDTH)
    ) u_stop_watchdog (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .xin_tick_i(xin_tick),
        .stop_load_i(stop_go),
        .ctrl_i(wdt_ctrl_i),
        .count_o(wdt_count),
        .f32_sel_o(wdt_sel)
    );

    assign osc_output_pin_o = osc_out_reg;
    assign osc_enable_o = osc_en_reg;
    assign phi_o = phi_reg;
    assign phi_tick_o = phi_tick_reg;
    assign bus_clk_o = bus_reg;
    assign periph_tick_o = periph_tick_reg;
    assign power_state_o = state_reg;
    assign wdt_count_o = wdt_count;
    assign wdt_f32_sel_o = wdt_sel;

    // =================================================================
    // Checks.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);

    chk_phi_half_rate: assert property (
        (run && xin_tick && !stop_go && !wait_go)
            |=> phi_reg != $past(phi_reg))
        else $error("internal clock did not toggle on input edge");

    chk_bus_half_phi: assert property (
        (run && xin_tick && !phi_reg && !stop_go && !wait_go)
            |=> bus_reg != $past(bus_reg) ##1 ($stable(bus_reg) || !run))
        else $error("bus cycle not halved from internal clock");

    chk_osc_gate_off: assert property (
        (!osc_en_reg ##1 !osc_en_reg) |-> !osc_out_reg && !xin_tick)
        else $error("oscillator active while gate closed");

    chk_stop_entry: assert property (
        stop_go |=> !osc_en_reg && !phi_reg && state_reg == ST_STOP)
        else $error("stop did not halt oscillator and clock");

    chk_stop_preset: assert property (
        stop_go |=> wdt_count == `WDT_PRESET && wdt_sel)
        else $error("watchdog not preset on stop");

    chk_sel_restore: assert property (
        (wdt_sel && !wdt_count[`WDT_MSB] && !stop_go) |=> !wdt_sel)
        else $error("watchdog source not restored");

    chk_settle_hold: assert property (
        (state_reg == ST_STOP && req_i.irq_accept)
            |=> osc_en_reg && !phi_reg && state_reg == ST_SETTLE)
        else $error("stop exit did not restart oscillator");

    chk_settle_low: assert property (
        (state_reg == ST_SETTLE && wdt_count[`WDT_MSB])
            |=> !phi_reg && !phi_tick_reg)
        else $error("clock ran before watchdog settled");

    chk_wait_osc: assert property (
        wait_go |=> state_reg == ST_WAIT && osc_en_reg && !phi_reg)
        else $error("wait stopped the oscillator");

    chk_wait_periph: assert property (
        (state_reg == ST_WAIT && xin_tick && periph_phase_reg)
            |=> periph_tick_reg)
        else $error("peripheral clock stopped in wait");

    chk_wait_exit: assert property (
        (state_reg == ST_WAIT && req_i.irq_accept) |=> run)
        else $error("wait exit delayed");

    chk_settle_release: assert property (
        (state_reg == ST_SETTLE && !wdt_count[`WDT_MSB]) |=> run)
        else $error("clock not released when bit 11 cleared");

    chk_stop_osc_off: assert property (
        state_reg == ST_STOP |-> !osc_en_reg)
        else $error("oscillator running in stop");

    chk_stop_bus_low: assert property (
        stop_go |=> !bus_reg && !phi_tick_reg)
        else $error("bus cycle not frozen on stop");

    chk_stop_ticks: assert property (
        state_reg == ST_STOP |=> !periph_tick_reg && !phi_tick_reg)
        else $error("clock pulse issued in stop");

    chk_settle_osc_on: assert property (
        state_reg == ST_SETTLE |-> osc_en_reg)
        else $error("oscillator off while settling");

    chk_settle_f32: assert property (
        (state_reg == ST_SETTLE && wdt_count[`WDT_MSB]) |-> wdt_sel)
        else $error("watchdog left the divided-by-32 source early");

    chk_wait_phi_low: assert property (
        state_reg == ST_WAIT |-> !phi_reg && !bus_reg)
        else $error("internal clock ran in wait");

    chk_phi_tick_rise: assert property (
        phi_tick_reg |-> $rose(phi_reg))
        else $error("clock pulse not aligned with rising clock");

    chk_irq_in_run: assert property (
        (run && req_i.irq_accept && !stop_go && !wait_go)
            |=> run && osc_en_reg)
        else $error("interrupt in run changed the power state");

    cov_stop_cycle: cover property (
        stop_go ##[1:300] state_reg == ST_SETTLE ##[1:1000] run);

    cov_wait_cycle: cover property (
        wait_go ##[1:300] (state_reg == ST_WAIT && req_i.irq_accept));

    cov_periph_in_wait: cover property (
        state_reg == ST_WAIT && periph_tick_reg);

    cov_stop_over_wait: cover property (
        stop_go && req_i.idle_cpu_clock_instruction);

    cov_fast_source: cover property (
        !wdt_sel && wdt_ctrl_i.freq_sel && $changed(wdt_count));

endmodule : clock_gen_stop_wait

// ==== sim/osc_source_model.sv ====
`timescale 1ns/100ps

// =====================================================================
// Resonator stand-in: a square wave of 2*HALF clocks while the gate is
// open. Only the input pin is driven; the output pin stays open.
module osc_source_model #(
    parameter int HALF = 2
) (
    input wire logic mclk_i,
    input wire logic run_i,
    output logic osc_o
);
    int cnt;

    initial begin
        osc_o = 1'b0;
        cnt = 0;
    end

    always @(negedge mclk_i) begin
        if (run_i !== 1'b1) begin
            // A stopped resonator settles low and restarts from scratch.
            osc_o <= 1'b0;
            cnt <= 0;
        end else if (cnt == HALF - 1) begin
            osc_o <= ~osc_o;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : osc_source_model

// ==== sim/clock_gen_stop_wait_tb.sv ====
`timescale 1ns/100ps

module clock_gen_stop_wait_tb;
    import clock_gen_pkg::*;

    // =================================================================
    // Signals and instances.
    logic mclk_i, srst_i, osc_in, osc_en, phi, phi_tick, bus_clk, ptick;
    logic f32_sel, osc_out;
    logic [11:0] wdt;
    cpu_req_s req;
    wdt_ctrl_s wctl;
    pwr_state_e st;
    int fail_count, total_checks;

    clock_gen_stop_wait u_clock_gen_stop_wait (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .osc_in_i(osc_in),
        .req_i(req),
        .wdt_ctrl_i(wctl),
        .osc_output_pin_o(osc_out),
        .osc_enable_o(osc_en),
        .phi_o(phi),
        .phi_tick_o(phi_tick),
        .bus_clk_o(bus_clk),
        .periph_tick_o(ptick),
        .power_state_o(st),
        .wdt_count_o(wdt),
        .wdt_f32_sel_o(f32_sel)
    );

    osc_source_model #(.HALF(2)) u_osc_source_model (
        .mclk_i(mclk_i),
        .run_i(osc_en),
        .osc_o(osc_in)
    );

    // =================================================================
    // Shared tasks.
    task chk(input string what, input logic [11:0] exp,
             input logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : chk

    task pulse(input logic [2:0] r);
        @(negedge mclk_i) req = r;
        @(negedge mclk_i) req = '0;
        @(negedge mclk_i);
    endtask : pulse

    // Counts the clocks between two successive events of one kind.
    task gap(input int w, output int n);
        int k;
        logic p, e;
        n = 0;
        k = 0;
        p = bus_clk;
        while (k < 2 && n < 500) begin
            @(negedge mclk_i);
            e = (w == 0) ? phi_tick : (w == 1) ? ptick : (bus_clk && !p);
            p = bus_clk;
            if (k == 1) n++;
            if (e === 1'b1) k++;
        end
    endtask : gap

    task phi_high(input int n, output int h);
        h = 0;
        repeat (n) begin
            @(negedge mclk_i);
            if (phi !== 1'b0) h++;
        end
    endtask : phi_high

    // =================================================================
    // Scenarios.
    task t_reset;
        chk("state", 12'(ST_RUN), 12'(st));
        chk("osc_en", 12'h001, 12'(osc_en));
        chk("wdt", 12'hFFF, wdt);
        chk("f32_sel", 12'h000, 12'(f32_sel));
    endtask : t_reset

    task t_run;
        int n;
        gap(0, n);
        chk("phi period", 12'd8, 12'(n));
        gap(2, n);
        chk("bus period", 12'd16, 12'(n));
        pulse(3'b001);
        chk("irq in run", 12'(ST_RUN), 12'(st));
    endtask : t_run

    task t_wait;
        int n, h;
        pulse(3'b010);
        chk("wait state", 12'(ST_WAIT), 12'(st));
        chk("wait osc_en", 12'h001, 12'(osc_en));
        h = 0;
        repeat (8) begin
            @(negedge mclk_i);
            if (osc_out === 1'b1) h++;
        end
        chk("wait osc_out", 12'd4, 12'(h));
        phi_high(100, n);
        chk("wait phi high", 12'h000, 12'(n));
        gap(1, n);
        chk("wait periph", 12'd8, 12'(n));
        pulse(3'b100);
        chk("stop in wait", 12'(ST_WAIT), 12'(st));
        pulse(3'b001);
        chk("wait exit", 12'(ST_RUN), 12'(st));
        gap(0, n);
        chk("resume phi", 12'd8, 12'(n));
    endtask : t_wait

    task t_stop;
        int n, h;
        pulse(3'b110);
        chk("stop state", 12'(ST_STOP), 12'(st));
        chk("stop osc_en", 12'h000, 12'(osc_en));
        chk("stop wdt", 12'hFFF, wdt);
        chk("stop f32", 12'h001, 12'(f32_sel));
        phi_high(100, n);
        chk("stop phi high", 12'h000, 12'(n));
        chk("frozen wdt", 12'hFFF, wdt);
        chk("stop osc_out", 12'h000, 12'(osc_out));
        pulse(3'b001);
        chk("settle state", 12'(ST_SETTLE), 12'(st));
        chk("settle osc_en", 12'h001, 12'(osc_en));
        n = 0;
        while (wdt === 12'hFFF && n < 300) begin
            @(negedge mclk_i);
            n++;
        end
        chk("first step", 12'hFFE, wdt);
        n = 0;
        h = 0;
        while (wdt === 12'hFFE && n < 300) begin
            @(negedge mclk_i);
            n++;
            if (phi !== 1'b0) h++;
        end
        chk("step spacing", 12'd128, 12'(n));
        chk("second step", 12'hFFD, wdt);
        chk("settle phi high", 12'h000, 12'(h));
        @(negedge mclk_i) srst_i = 1'b1;
        @(negedge mclk_i) srst_i = 1'b0;
        @(negedge mclk_i);
        chk("reset f32", 12'h000, 12'(f32_sel));
        chk("reset state", 12'(ST_RUN), 12'(st));
    endtask : t_stop

    task t_source;
        int n;
        wctl.freq_sel = 1'b1;
        n = 0;
        while (wdt === 12'hFFF && n < 200) begin
            @(negedge mclk_i);
            n++;
        end
        chk("fast first", 12'hFFE, wdt);
        n = 0;
        while (wdt === 12'hFFE && n < 200) begin
            @(negedge mclk_i);
            n++;
        end
        chk("fast spacing", 12'd64, 12'(n));
        chk("fast second", 12'hFFD, wdt);
        @(negedge mclk_i) wctl.restart = 1'b1;
        @(negedge mclk_i) wctl.restart = 1'b0;
        chk("restart wdt", 12'hFFF, wdt);
    endtask : t_source

    // =================================================================
    // Verdict, clock, watchdog and main sequence.
    task print_verdict;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        fail_count++;
        print_verdict();
    end

    initial begin
        fail_count = 0;
        total_checks = 0;
        srst_i = 1'b1;
        req = '0;
        wctl = '0;
        repeat (16) @(negedge mclk_i);
        srst_i = 1'b0;
        @(negedge mclk_i);
        t_reset();
        t_run();
        t_wait();
        t_stop();
        t_source();
        print_verdict();
    end
endmodule : clock_gen_stop_wait_tb
